// File: design/lin_node_mode_config.sv
// lin node mode configuration and control with apb register access
// assumes apb master on i_clk, dma write port and frame engine on same clock
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "lin_cfg.svh"
module lin_node_mode_config
    import lin_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_dma_wr_valid,
    input  wire logic [31:0] i_dma_wr_data,
    output logic             o_dma_wr_ready,
    input  wire logic        i_rx_id_valid,
    input  wire logic [7:0]  i_rx_id,
    input  wire logic        i_rx_data_valid,
    input  wire logic [7:0]  i_rx_data,
    output logic             o_rx_data_ready,
    input  wire logic        i_wake_pin,
    output logic [7:0]       o_tx_id,
    output frame_ctrl_t      o_frame_ctrl,
    output logic             o_wakeup_line
);
    // ======================================================
    // register state
    mode_cfg_t   mode_q;
    logic [7:0]  ident_q;
    logic [3:0]  port_mode_q;
    logic        rx_pol_q;
    logic        drift_q;
    logic        over16_q;
    logic        rx_id_seen_q;
    logic        wake_pin_s;
    frame_ctrl_t ctrl_d;
    frame_ctrl_t ctrl_q;
    logic [31:0] rdata_q;
    wake_state_t wk_q;
    logic [15:0] wk_cnt_q;
    logic        wake_line_q;

    logic        acc;
    logic        wr;
    logic        rd;
    logic        is_master;
    logic        is_slave;
    logic        mapped;
    logic        fifo_valid;
    logic [7:0]  fifo_data;
    logic        fifo_pop;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;

    localparam logic [15:0] WAKE_NEW_CYC = 16'(`WAKE_PULSE_CYC);
    localparam logic [15:0] WAKE_OLD_CYC = 16'(`WAKE_PULSE_CYC * 2);

    initial
    begin
        if (FIFO_DEPTH != 32)
            $error("lin_node_mode_config: receive fifo must hold 32 words");
    end

    assign acc       = i_psel && i_penable;
    assign wr        = acc && i_pwrite;
    assign rd        = acc && !i_pwrite;
    assign is_master = port_mode_q == `PORT_MODE_MASTER;
    assign is_slave  = port_mode_q == `PORT_MODE_SLAVE;
    assign mapped    = i_paddr inside {`OFS_MODE_CONFIG, `OFS_IDENT_CHAR, `OFS_CONTROL,
                                       `OFS_PORT_MODE, `OFS_MANCHESTER, `OFS_STATUS, `OFS_FIFO_DATA};
    assign o_pready  = 1'b1;
    assign o_pslverr = acc && !mapped;
    assign o_prdata  = rdata_q;

    // ======================================================
    // pin synchroniser
    lin_sync #(.WIDTH(1)) u_wake_sync
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_wake_pin),
        .o_sync  (wake_pin_s)
    );

    // ======================================================
    // receive data fifo
    assign fifo_pop = rd && i_paddr == `OFS_FIFO_DATA;

    lin_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo
    (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (i_rx_data_valid),
        .o_in_ready  (o_rx_data_ready),
        .i_in_data   (i_rx_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_data),
        .o_level     (fifo_level)
    );

    // ======================================================
    // mode register: apb and dma writers
    assign o_dma_wr_ready = mode_q.dma_write_mode && !(wr && i_paddr == `OFS_MODE_CONFIG);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            mode_q <= mode_cfg_t'(`MODE_CFG_RESET);
        else if (wr && i_paddr == `OFS_MODE_CONFIG)
            mode_q <= mode_cfg_t'(i_pwdata[16:0]);
        else if (i_dma_wr_valid && o_dma_wr_ready)
            mode_q <= mode_cfg_t'({mode_q.dma_write_mode, i_dma_wr_data[15:0]});
    end

    // ======================================================
    // identifier character
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ident_q <= `IDENT_RESET;
        else if (is_slave && i_rx_id_valid)
            ident_q <= i_rx_id;
        else if (is_master && wr && i_paddr == `OFS_IDENT_CHAR)
            ident_q <= i_pwdata[7:0];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rx_id_seen_q <= 1'b0;
        else if (is_slave && i_rx_id_valid)
            rx_id_seen_q <= 1'b1;
        else if (rd && i_paddr == `OFS_STATUS)
            rx_id_seen_q <= 1'b0;
    end

    // ======================================================
    // port mode and manchester registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            port_mode_q <= 4'h0;
            rx_pol_q    <= 1'b0;
            drift_q     <= 1'b0;
            over16_q    <= 1'b0;
        end
        else if (wr && i_paddr == `OFS_PORT_MODE)
            port_mode_q <= i_pwdata[3:0];
        else if (wr && i_paddr == `OFS_MANCHESTER)
        begin
            rx_pol_q <= i_pwdata[`POS_MAN_RX_POL];
            drift_q  <= i_pwdata[`POS_MAN_DRIFT];
            over16_q <= i_pwdata[`POS_MAN_OVER16];
        end
    end

    // ======================================================
    // read data
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rdata_q <= 32'h0;
        else if (i_psel && !i_penable && !i_pwrite)
        begin
            case (i_paddr)
                `OFS_MODE_CONFIG : rdata_q <= {15'h0, mode_q};
                `OFS_IDENT_CHAR  : rdata_q <= {24'h0, ident_q};
                `OFS_PORT_MODE   : rdata_q <= {28'h0, port_mode_q};
                `OFS_MANCHESTER  : rdata_q <= {over16_q, drift_q, 1'b0, rx_pol_q, 28'h0};
                `OFS_STATUS      : rdata_q <= {16'h0, 2'h0, wk_q != WK_IDLE, rx_id_seen_q,
                                               wake_pin_s, 5'h0, fifo_level};
                `OFS_FIFO_DATA   : rdata_q <= {23'h0, fifo_valid, fifo_data};
                default          : rdata_q <= 32'h0;
            endcase
        end
    end

    // ======================================================
    // frame control decode
    always_comb
    begin
        ctrl_d = '0;
        ctrl_d.tx_response       = mode_q.node_response_action == ACT_PUBLISH;
        ctrl_d.rx_response       = mode_q.node_response_action == ACT_SUBSCRIBE;
        ctrl_d.tx_parity         = is_master && !mode_q.id_parity_disable;
        ctrl_d.chk_parity        = (is_master || is_slave) && !mode_q.id_parity_disable;
        ctrl_d.tx_checksum       = is_master && !mode_q.checksum_disable;
        ctrl_d.chk_checksum      = is_slave && !mode_q.checksum_disable;
        ctrl_d.enhanced_checksum = !mode_q.checksum_kind;
        ctrl_d.frame_slot_en     = !mode_q.frame_slot_disable;
        ctrl_d.rx_pol_invert     = rx_pol_q;
        ctrl_d.drift_recover     = drift_q && over16_q;
        if (!mode_q.length_source_select)
            ctrl_d.response_len = {1'b0, mode_q.response_length_ctrl} + 9'h1;
        else
        begin
            case (ident_q[6:5])
                2'h0    : ctrl_d.response_len = 9'h2;
                2'h1    : ctrl_d.response_len = 9'h2;
                2'h2    : ctrl_d.response_len = 9'h4;
                default : ctrl_d.response_len = 9'h8;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ctrl_q <= '0;
        else
            ctrl_q <= ctrl_d;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_tx_id <= 8'h0;
        else
            o_tx_id <= is_master ? ident_q : 8'h0;
    end

    assign o_frame_ctrl = ctrl_q;

    // ======================================================
    // wakeup generator
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wk_q     <= WK_IDLE;
            wk_cnt_q <= 16'h0;
        end
        else
        begin
            case (wk_q)
                WK_IDLE :
                begin
                    if (wr && i_paddr == `OFS_CONTROL && i_pwdata[`POS_CTRL_WAKEUP])
                    begin
                        wk_q     <= mode_q.wakeup_kind ? WK_OLD : WK_NEW;
                        wk_cnt_q <= mode_q.wakeup_kind ? WAKE_OLD_CYC : WAKE_NEW_CYC;
                    end
                end
                WK_NEW, WK_OLD :
                begin
                    if (wk_cnt_q == 16'h1)
                        wk_q <= WK_IDLE;
                    wk_cnt_q <= wk_cnt_q - 16'h1;
                end
                default : wk_q <= WK_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            wake_line_q <= 1'b0;
        else
            wake_line_q <= wk_q != WK_IDLE;
    end

    assign o_wakeup_line = wake_line_q;

    // ======================================================
    // checks
    property p_dma_blocked;
        @(posedge i_clk) disable iff (i_rst)
        !mode_q.dma_write_mode |-> !o_dma_wr_ready;
    endproperty
    a_dma_blocked : assert property (p_dma_blocked) else $error("dma write allowed");

    property p_dma_keeps_flag;
        @(posedge i_clk) disable iff (i_rst)
        (i_dma_wr_valid && o_dma_wr_ready) |=> mode_q.dma_write_mode;
    endproperty
    a_dma_keeps_flag : assert property (p_dma_keeps_flag) else $error("dma changed mode flag");

    property p_slave_capture;
        @(posedge i_clk) disable iff (i_rst)
        (is_slave && i_rx_id_valid) |=> ident_q == $past(i_rx_id);
    endproperty
    a_slave_capture : assert property (p_slave_capture) else $error("slave id not captured");

    property p_slave_ro;
        @(posedge i_clk) disable iff (i_rst)
        (is_slave && !i_rx_id_valid) |=> $stable(ident_q);
    endproperty
    a_slave_ro : assert property (p_slave_ro) else $error("slave id written");

    property p_master_write;
        @(posedge i_clk) disable iff (i_rst)
        (is_master && wr && i_paddr == `OFS_IDENT_CHAR) |=> ##1 o_tx_id == $past(i_pwdata[7:0], 2);
    endproperty
    a_master_write : assert property (p_master_write) else $error("master id not sent");

    property p_len_reg;
        @(posedge i_clk) disable iff (i_rst)
        !i_rst && !mode_q.length_source_select |=> o_frame_ctrl.response_len == 9'($past(mode_q.response_length_ctrl)) + 9'h1;
    endproperty
    a_len_reg : assert property (p_len_reg) else $error("length mismatch");

    property p_parity_off;
        @(posedge i_clk) disable iff (i_rst)
        mode_q.id_parity_disable |=> !o_frame_ctrl.tx_parity && !o_frame_ctrl.chk_parity;
    endproperty
    a_parity_off : assert property (p_parity_off) else $error("parity active when disabled");

    property p_chk_off;
        @(posedge i_clk) disable iff (i_rst)
        mode_q.checksum_disable |=> !o_frame_ctrl.tx_checksum && !o_frame_ctrl.chk_checksum;
    endproperty
    a_chk_off : assert property (p_chk_off) else $error("checksum active when disabled");

    property p_wake_len;
        @(posedge i_clk) disable iff (i_rst)
        (wk_q == WK_IDLE && wr && i_paddr == `OFS_CONTROL && i_pwdata[0] && !mode_q.wakeup_kind)
            |=> ##1 o_wakeup_line [*8];
    endproperty
    a_wake_len : assert property (p_wake_len) else $error("wakeup pulse short");

    c_wake_old  : cover property (@(posedge i_clk) wk_q == WK_OLD);
    c_dma_write : cover property (@(posedge i_clk) i_dma_wr_valid && o_dma_wr_ready);
    c_slave_id  : cover property (@(posedge i_clk) is_slave && i_rx_id_valid);
    c_fifo_full : cover property (@(posedge i_clk) !o_rx_data_ready);
endmodule
`default_nettype wire

// File: design/lin_cfg.svh
// constants for the lin node mode configuration block
// assumes an apb slave with 32-bit data and word aligned registers
//
// What this block does
// - node action field selects transmit, receive or ignore response; value three reserved
// - parity enable: master computes and sends id parity; both nodes check it
// - parity disabled: no id parity computed, sent or checked in any node role
// - checksum enable: master computes and appends checksum, slave checks received checksum
// - checksum disabled: no checksum computed, sent or checked in any node role
// - checksum kind zero selects enhanced checksum, one selects classic checksum
// - length source zero takes response length from the length control field
// - length source one derives response length from identifier bits five and six
// - length control value plus one gives response length in bytes
// - frame slot disable zero enables frame slot mode, one disables it
// - wakeup command sends new style wakeup when kind zero, old style when one
// - dma may write mode register except dma mode bit, only when that bit set
// - master port mode: identifier char is read write, holds identifier to send
// - slave port mode: identifier char read only, holds last received identifier
// - rx manchester polarity zero: rising is zero, falling is one; one inverts
// - drift bit one enables drift recovery; requires sixteen times oversampling mode
`ifndef LIN_CFG_SVH
`define LIN_CFG_SVH

// ======================================================
// register offsets
`define OFS_MODE_CONFIG   12'h000
`define OFS_IDENT_CHAR    12'h004
`define OFS_CONTROL       12'h008
`define OFS_PORT_MODE     12'h00c
`define OFS_MANCHESTER    12'h010
`define OFS_STATUS        12'h014
`define OFS_FIFO_DATA     12'h018

// ======================================================
// mode config fields
`define POS_NODE_ACT      0
`define POS_PAR_DIS       2
`define POS_CHK_DIS       3
`define POS_CHK_KIND      4
`define POS_LEN_SRC       5
`define POS_FSLOT_DIS     6
`define POS_WAKE_KIND     7
`define POS_LEN_CTRL      8
`define POS_DMA_MODE      16
`define MODE_CFG_MASK     32'h0001ffff
`define MODE_DMA_MASK     32'h0000ffff
`define MODE_CFG_RESET    32'h00000000

// ======================================================
// port mode, control, manchester fields
`define PORT_MODE_MASTER  4'ha
`define PORT_MODE_SLAVE   4'hb
`define POS_CTRL_WAKEUP   0
`define POS_MAN_RX_POL    28
`define POS_MAN_DRIFT     30
`define POS_MAN_OVER16    31
`define IDENT_RESET       8'h00

// ======================================================
// timing
`define WAKE_PULSE_NS     1000
`define WAKE_PULSE_CYC    ((`WAKE_PULSE_NS + 3) / 4)

`endif

// File: design/lin_pkg.sv
// types for the lin node mode configuration block
// assumes lin_cfg.svh for all numeric constants
package lin_pkg;

    typedef enum logic [1:0]
    {
        ACT_PUBLISH   = 2'h0,
        ACT_SUBSCRIBE = 2'h1,
        ACT_IGNORE    = 2'h2,
        ACT_RESERVED  = 2'h3
    } node_action_t;

    typedef struct packed
    {
        logic         dma_write_mode;
        logic [7:0]   response_length_ctrl;
        logic         wakeup_kind;
        logic         frame_slot_disable;
        logic         length_source_select;
        logic         checksum_kind;
        logic         checksum_disable;
        logic         id_parity_disable;
        node_action_t node_response_action;
    } mode_cfg_t;

    typedef struct packed
    {
        logic       tx_response;
        logic       rx_response;
        logic       tx_parity;
        logic       chk_parity;
        logic       tx_checksum;
        logic       chk_checksum;
        logic       enhanced_checksum;
        logic       frame_slot_en;
        logic [8:0] response_len;
        logic       drift_recover;
        logic       rx_pol_invert;
    } frame_ctrl_t;

    typedef enum logic [2:0]
    {
        WK_IDLE = 3'b001,
        WK_NEW  = 3'b010,
        WK_OLD  = 3'b100
    } wake_state_t;

endpackage

// File: design/lin_fifo.sv
// synchronous fifo with valid and ready on both sides
// assumes one clock, synchronous active high reset
`timescale 1ns/1ns
`default_nettype none
module lin_fifo
    import lin_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic      [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("lin_fifo: depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (wr_q - rd_q) != DEPTH[AW:0];
    assign o_out_valid = wr_q != rd_q;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_q[AW-1:0]];
    assign o_level     = wr_q - rd_q;

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= i_in_data;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end

    property p_no_overflow;
        @(posedge i_clk) disable iff (i_rst)
        o_level <= DEPTH[AW:0];
    endproperty
    a_no_overflow : assert property (p_no_overflow) else $error("fifo level above depth");
endmodule
`default_nettype wire

// File: design/lin_sync.sv
// two flip-flop synchroniser for pin levels
// assumes asynchronous inputs, one clock
`timescale 1ns/1ns
`default_nettype none
module lin_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    initial
    begin
        if (WIDTH < 1)
            $error("lin_sync: width must be positive");
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule
`default_nettype wire

// File: sim/lin_bus_node_model.sv
// bus node model: identifiers, response bytes and wake level
// assumes the block's frame engine side on the same clock
`timescale 1ns/1ns
`default_nettype none
module lin_bus_node_model
(
    input  wire logic       i_clk,
    input  wire logic       i_data_ready,
    output logic            o_id_valid,
    output logic [7:0]      o_id,
    output logic            o_data_valid,
    output logic [7:0]      o_data,
    output logic            o_wake
);
    // ========================================
    // idle at time zero
    initial
    begin
        o_id_valid   = 1'b0;
        o_id         = 8'h00;
        o_data_valid = 1'b0;
        o_data       = 8'h00;
        o_wake       = 1'b0;
    end

    // ========================================
    // one cycle identifier pulse, line scrambled after
    task automatic send_id(input logic [7:0] id);
        o_id_valid <= 1'b1;
        o_id       <= id;
        @(posedge i_clk);
        o_id_valid <= 1'b0;
        o_id       <= ~id;
    endtask

    // ========================================
    // bytes held until taken, idle cycle between bytes
    task automatic send_bytes(input int n, input logic [7:0] base);
        for (int k = 0; k < n; k++)
        begin
            o_data_valid <= 1'b1;
            o_data       <= base + 8'(k);
            @(posedge i_clk);
            while (i_data_ready !== 1'b1)
                @(posedge i_clk);
            o_data_valid <= 1'b0;
            o_data       <= ~(base + 8'(k));
            @(posedge i_clk);
        end
    endtask

    task automatic set_wake(input logic lvl);
        o_wake <= lvl;
    endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the lin node mode configuration block
// assumes the design package, constants header and bus node model
`timescale 1ns/1ns
`default_nettype none
`include "lin_cfg.svh"
module tb
    import lin_pkg::*;
();
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        slverr;
    logic        dma_valid;
    logic [31:0] dma_data;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        o_dma_wr_ready;
    logic        id_valid;
    logic [7:0]  id;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        o_rx_data_ready;
    logic        wake;
    logic [7:0]  o_tx_id;
    frame_ctrl_t o_frame_ctrl;
    logic        o_wakeup_line;
    int          n_errors = 0;
    int          tests_run = 0;
    logic [31:0] cfgs [4] = '{32'h0, 32'hff5d, 32'h86, 32'h0b0b};

    lin_node_mode_config lin_node_mode_config_inst (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_dma_wr_valid(dma_valid), .i_dma_wr_data(dma_data),
        .o_dma_wr_ready(o_dma_wr_ready), .i_rx_id_valid(id_valid), .i_rx_id(id), .i_rx_data_valid(rx_valid),
        .i_rx_data(rx_data), .o_rx_data_ready(o_rx_data_ready), .i_wake_pin(wake), .o_tx_id(o_tx_id),
        .o_frame_ctrl(o_frame_ctrl), .o_wakeup_line(o_wakeup_line));

    lin_bus_node_model lin_bus_node_model_inst (.i_clk(clk), .i_data_ready(o_rx_data_ready),
        .o_id_valid(id_valid), .o_id(id), .o_data_valid(rx_valid), .o_data(rx_data), .o_wake(wake));

    always #2 clk = ~clk;

    // ========================================
    // bus tasks and comparison
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (o_pready !== 1'b1)
            @(posedge clk);
        rd = o_prdata;
        slverr = o_pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] x;
        apb(1'b1, a, v, x);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        apb(1'b0, a, 32'h0, v);
    endtask

    task automatic dma(input logic [31:0] v);
        int w;
        w = 0;
        dma_valid <= 1'b1;
        dma_data  <= v;
        @(posedge clk);
        while (o_dma_wr_ready !== 1'b1 && w < 8)
        begin
            @(posedge clk);
            w++;
        end
        dma_valid <= 1'b0;
        dma_data  <= ~v;
        @(posedge clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] exp_fc(input logic [16:0] v, input logic [3:0] pm, input logic [7:0] i,
                                          input logic [31:0] mn);
        frame_ctrl_t f;
        mode_cfg_t   m;
        logic        ms;
        logic        sl;
        m = mode_cfg_t'(v);
        ms = pm == `PORT_MODE_MASTER;
        sl = pm == `PORT_MODE_SLAVE;
        f.tx_response = m.node_response_action == ACT_PUBLISH;
        f.rx_response = m.node_response_action == ACT_SUBSCRIBE;
        f.tx_parity = ms & !m.id_parity_disable;
        f.chk_parity = (ms | sl) & !m.id_parity_disable;
        f.tx_checksum = ms & !m.checksum_disable;
        f.chk_checksum = sl & !m.checksum_disable;
        f.enhanced_checksum = !m.checksum_kind;
        f.frame_slot_en = !m.frame_slot_disable;
        f.response_len = m.length_source_select ? (i[6] ? (i[5] ? 9'h8 : 9'h4) : 9'h2)
                                                : 9'(m.response_length_ctrl) + 9'h1;
        f.drift_recover = mn[30] & mn[31];
        f.rx_pol_invert = mn[28];
        return 32'(f);
    endfunction

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ========================================
    // watchdog
    initial
    begin
        #80000;
        n_errors++;
        tally_and_finish();
    end

    // ========================================
    // main sequence
    initial
    begin
        logic [31:0] d;
        int          n;
        logic [7:0]  ids [4];
        ids = '{8'h0a, 8'h2a, 8'h4a, 8'h6a};
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        dma_valid = 1'b0;
        dma_data = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`OFS_MODE_CONFIG, d);
        check(d, `MODE_CFG_RESET);
        check(32'(o_frame_ctrl), exp_fc(17'h0, 4'h0, 8'h0, 32'h0));
        for (int i = 0; i < 8; i++)
        begin
            wr(`OFS_PORT_MODE, i[0] ? 32'hb : 32'ha);
            wr(`OFS_MODE_CONFIG, cfgs[i / 2]);
            repeat (3) @(posedge clk);
            check(32'(o_frame_ctrl), exp_fc(cfgs[i / 2][16:0], i[0] ? 4'hb : 4'ha, 8'h0, 32'h0));
        end
        wr(`OFS_PORT_MODE, 32'ha);
        wr(`OFS_MODE_CONFIG, 32'h20);
        for (int i = 0; i < 4; i++)
        begin
            wr(`OFS_IDENT_CHAR, {24'h0, ids[i]});
            rd(`OFS_IDENT_CHAR, d);
            check(d, {24'h0, ids[i]});
            check({24'h0, o_tx_id}, {24'h0, ids[i]});
            check(32'(o_frame_ctrl), exp_fc(17'h20, 4'ha, ids[i], 32'h0));
        end
        wr(`OFS_PORT_MODE, 32'hb);
        lin_bus_node_model_inst.send_id(8'h3c);
        wr(`OFS_IDENT_CHAR, 32'h11);
        rd(`OFS_IDENT_CHAR, d);
        check(d, 32'h3c);
        check({24'h0, o_tx_id}, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            wr(`OFS_MANCHESTER, i ? 32'hd000_0000 : 32'h5000_0000);
            repeat (3) @(posedge clk);
            check(32'(o_frame_ctrl), exp_fc(17'h20, 4'hb, 8'h3c, i ? 32'hd000_0000 : 32'h5000_0000));
        end
        wr(`OFS_MODE_CONFIG, 32'h0);
        dma(32'h00ff);
        rd(`OFS_MODE_CONFIG, d);
        check(d, 32'h0);
        wr(`OFS_MODE_CONFIG, 32'h1_0000);
        dma(32'h0123);
        rd(`OFS_MODE_CONFIG, d);
        check(d, 32'h1_0123);
        for (int k = 0; k < 2; k++)
        begin
            wr(`OFS_MODE_CONFIG, k ? 32'h80 : 32'h0);
            wr(`OFS_CONTROL, 32'h1);
            n = 0;
            while (o_wakeup_line !== 1'b1 && n < 10)
            begin
                @(negedge clk);
                n++;
            end
            n = 0;
            while (o_wakeup_line === 1'b1 && n < 2000)
            begin
                @(negedge clk);
                n++;
            end
            @(posedge clk);
            check(32'(n), 32'(`WAKE_PULSE_CYC * (k + 1)));
        end
        lin_bus_node_model_inst.set_wake(1'b1);
        lin_bus_node_model_inst.send_bytes(32, 8'h40);
        @(negedge clk);
        check({31'h0, o_rx_data_ready}, 32'h0);
        @(posedge clk);
        rd(`OFS_STATUS, d);
        check({26'h0, d[5:0]}, 32'h20);
        check({31'h0, d[11]}, 32'h1);
        check({31'h0, d[12]}, 32'h1);
        for (int k = 0; k < 32; k++)
        begin
            rd(`OFS_FIFO_DATA, d);
            check({23'h0, d[8:0]}, {23'h0, 1'b1, 8'h40 + 8'(k)});
        end
        rd(`OFS_FIFO_DATA, d);
        check({31'h0, d[8]}, 32'h0);
        rd(12'h01c, d);
        check({31'h0, slverr}, 32'h1);
        check(d, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
